// file: hw/dmpg_top.sv
/*
 drive monitor and parameter guard: encoder counters, status words, password
 and write lock, quick display mode, restore commands; apb slave for software.
 assumes quadrature and index pins asynchronous to pclk, drive status from
 pclk-domain logic, and a parameter store that acts on the restore strobes.
*/
// The implementer's own choices: the placing of the registers and the APB register port.
// Behaviour
// - position count moves once per a/b edge, four per encoder line
// - count up on forward rotation, down on reverse rotation
// - increment at 65535 wraps to zero
// - decrement at zero wraps to 65535
// - index counter steps plus or minus one per revolution, 16 bits
// - resolver angle read back as unsigned 0 to 4095
// - run word bits 1:0 are stop, forward, reverse
// - run word bits 3:2 are constant, accelerating, decelerating
// - run word bit 4 set on low dc bus voltage
// - set and run frequency as signed hundredths of percent of maximum
// - functions 1-40 on five digits, lowest group rightmost
// - functions 41-59 on three digits, right to left
// - non-zero password enables protection
// - protected parameters unreadable and unwritable until password matches
// - writing zero to password clears it and disables protection
// - lock 0 allows writes, lock 1 makes all read-only, default 0; the code keeps the lock itself writable under lock 1
// - quick key cycles full list and enabled user and changed modes
// - code prefix u in user mode, c in changed mode
// - command 1 restores all but motor, resolution, records, totals
// - command 2 restores every parameter including motor
// - command 4 clears records and totals; 3 and above 4 do nothing
`timescale 1ns/1ps
`default_nettype none
module dmpg_top #(
  parameter int unsigned ANGLE_W = 12,
  parameter int unsigned COUNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dmpg_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_z,
  input wire logic [ANGLE_W-1:0] resolver_angle_in,
  input wire dmpg_pkg::dmpg_drive_s drive_in,
  input wire logic [15:0] set_freq,
  input wire logic [15:0] run_freq,
  input wire logic [15:0] max_output_frequency,
  input wire logic [39:0] di_func_lo,
  input wire logic [18:0] di_func_hi,
  input wire logic restore_done,
  output dmpg_pkg::dmpg_restore_s restore_req,
  output logic restore_strobe,
  output logic param_write_allowed,
  output logic param_view_allowed,
  output logic [7:0] code_prefix
);
  import dmpg_pkg::*;

  // three-stage sync; stage 1 read only by stage 2
  logic [2:0] a_sy, b_sy, z_sy;
  logic a_st, b_st, z_st;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_sy <= 3'h0;
      b_sy <= 3'h0;
      z_sy <= 3'h0;
    end else begin
      a_sy <= {a_sy[1:0], enc_a};
      b_sy <= {b_sy[1:0], enc_b};
      z_sy <= {z_sy[1:0], enc_z};
    end
  end

  // a change counts once stages 2 and 3 agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_st <= 1'b0;
      b_st <= 1'b0;
      z_st <= 1'b0;
    end else begin
      if (a_sy[1] == a_sy[2]) a_st <= a_sy[2];
      if (b_sy[1] == b_sy[2]) b_st <= b_sy[2];
      if (z_sy[1] == z_sy[2]) z_st <= z_sy[2];
    end
  end

  // previous settled state for edge decode
  logic a_q, b_q, z_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      z_q <= 1'b0;
    end else begin
      a_q <= a_st;
      b_q <= b_st;
      z_q <= z_st;
    end
  end

  // gray-step decode: forward when a leads b; double steps are ignored
  logic step_fwd, step_rev, a_edge, b_edge;
  always_comb begin
    a_edge = a_st ^ a_q;
    b_edge = b_st ^ b_q;
    step_fwd = 1'b0;
    step_rev = 1'b0;
    if (a_edge && !b_edge) begin
      step_fwd = (a_st != b_st);
      step_rev = (a_st == b_st);
    end else if (b_edge && !a_edge) begin
      step_fwd = (a_st == b_st);
      step_rev = (a_st != b_st);
    end
  end

  // last direction seen decides the sign of an index pulse
  logic dir_rev_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dir_rev_r <= 1'b0;
    else if (step_fwd) dir_rev_r <= 1'b0;
    else if (step_rev) dir_rev_r <= 1'b1;
  end

  // natural modulo wrap of the counter gives both wrap cases
  logic [COUNT_W-1:0] quad_pos_r, index_rev_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quad_pos_r <= '0;
    else if (step_fwd) quad_pos_r <= quad_pos_r + 1'b1;
    else if (step_rev) quad_pos_r <= quad_pos_r - 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) index_rev_r <= '0;
    else if (z_st && !z_q) begin
      if (dir_rev_r) index_rev_r <= index_rev_r - 1'b1;
      else index_rev_r <= index_rev_r + 1'b1;
    end
  end

  // status capture
  logic [ANGLE_W-1:0] angle_r;
  logic [15:0] run_word_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      angle_r <= '0;
      run_word_r <= 16'h0000;
    end else begin
      angle_r <= resolver_angle_in;
      run_word_r <= {11'h000, drive_in.dc_low, drive_in.trend, drive_in.dir};
    end
  end

  // percent scaling: one divider per readout; slow but combinational
  function automatic logic [15:0] to_pct(input logic [15:0] f, input logic [15:0] fmax);
    logic signed [31:0] num;
    logic signed [31:0] q;
    logic signed [31:0] lim;
    // the limit is kept signed so a negative quotient is not compared as huge
    lim = $signed(32'(PCT_FULL));
    num = 32'($signed(f)) * 32'(PCT_FULL);
    if (fmax == 16'h0000) q = 32'h0;
    else q = num / $signed({16'h0000, fmax});
    if (q > lim) q = lim;
    if (q < -lim) q = -lim;
    return q[15:0];
  endfunction

  logic [15:0] set_pct_r, run_pct_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_pct_r <= 16'h0000;
      run_pct_r <= 16'h0000;
    end else begin
      set_pct_r <= to_pct(set_freq, max_output_frequency);
      run_pct_r <= to_pct(run_freq, max_output_frequency);
    end
  end

  // digit k occupies byte k, byte 0 is the rightmost digit
  logic [39:0] seg1_r;
  logic [23:0] seg2_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg1_r <= 40'h0;
      seg2_r <= 24'h0;
    end else begin
      seg1_r <= di_func_lo;
      seg2_r <= {5'h00, di_func_hi};
    end
  end

  // apb decode, zero wait states
  logic wr_en, rd_en;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  logic [15:0] password_r;
  logic unlocked_r, lock_r;
  logic [7:0] quick_sel_r, restore_cmd_r;
  logic protect;
  assign protect = (password_r != PASSWORD_RST);

  // guard for ordinary parameters
  logic view_ok, mod_ok;
  assign view_ok = !protect || unlocked_r;
  assign mod_ok = view_ok && (lock_r == WRITE_LOCK_RST);

  logic is_param_addr;
  always_comb begin
    case (paddr)
      OFF_USER_PASSWORD, OFF_WRITE_LOCK, OFF_QUICK_SELECT, OFF_RESTORE_CMD: is_param_addr = 1'b1;
      default: is_param_addr = 1'b0;
    endcase
  end

  logic wr_param;
  assign wr_param = wr_en && mod_ok && (pstrb[0] || pstrb[1]);

  // the lock itself stays writable so it can be released again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lock_r <= WRITE_LOCK_RST;
    else if (wr_en && view_ok && pstrb[0] && paddr == OFF_WRITE_LOCK) lock_r <= pwdata[0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) password_r <= PASSWORD_RST;
    else if (wr_param && paddr == OFF_USER_PASSWORD) password_r <= pwdata[15:0];
  end

  // matching entry unlocks; a fresh password write leaves the writer unlocked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) unlocked_r <= 1'b0;
    else if (wr_en && paddr == OFF_PASSWORD_ENTRY) unlocked_r <= (pwdata[15:0] == password_r);
    else if (wr_param && paddr == OFF_USER_PASSWORD) unlocked_r <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quick_sel_r <= QUICK_SELECT_RST;
    else if (wr_param && paddr == OFF_QUICK_SELECT) quick_sel_r <= pwdata[7:0];
  end

  // quick key: full -> user -> changed -> full, skipping disabled modes
  dmpg_mode_e mode_r, mode_nxt;
  logic user_en, chg_en, quick_press;
  assign user_en = quick_sel_r[QUICK_USER_BIT];
  assign chg_en = quick_sel_r[QUICK_CHANGED_BIT];
  assign quick_press = wr_en && paddr == OFF_QUICK_KEY && pwdata[0];
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      DMPG_MODE_FULL: begin
        if (user_en) mode_nxt = DMPG_MODE_USER;
        else if (chg_en) mode_nxt = DMPG_MODE_CHANGED;
      end
      DMPG_MODE_USER: begin
        mode_nxt = chg_en ? DMPG_MODE_CHANGED : DMPG_MODE_FULL;
      end
      DMPG_MODE_CHANGED: begin
        mode_nxt = DMPG_MODE_FULL;
      end
      default: begin
        mode_nxt = DMPG_MODE_FULL;
      end
    endcase
  end

  // a mode whose enable is withdrawn drops back to the full list
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mode_r <= DMPG_MODE_FULL;
    else if (quick_press) mode_r <= mode_nxt;
    else if ((mode_r == DMPG_MODE_USER && !user_en) || (mode_r == DMPG_MODE_CHANGED && !chg_en))
      mode_r <= DMPG_MODE_FULL;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) code_prefix <= SYM_NONE;
    else begin
      case (mode_r)
        DMPG_MODE_USER: code_prefix <= SYM_USER;
        DMPG_MODE_CHANGED: code_prefix <= SYM_CHANGED;
        default: code_prefix <= SYM_NONE;
      endcase
    end
  end

  // restore sequencer
  dmpg_rst_e rs_r;
  logic cmd_valid;
  assign cmd_valid = (restore_cmd_r == CMD_RESTORE_PART) || (restore_cmd_r == CMD_RESTORE_ALL) ||
                     (restore_cmd_r == CMD_CLEAR_RECORDS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) restore_cmd_r <= RESTORE_RST;
    else if (rs_r == DMPG_RS_DONE) restore_cmd_r <= CMD_NONE;
    else if (rs_r == DMPG_RS_IDLE && wr_param && paddr == OFF_RESTORE_CMD)
      restore_cmd_r <= pwdata[7:0];
    else if (rs_r == DMPG_RS_IDLE && !cmd_valid) restore_cmd_r <= CMD_NONE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs_r <= DMPG_RS_IDLE;
      restore_req <= '0;
      restore_strobe <= 1'b0;
    end else begin
      restore_strobe <= 1'b0;
      case (rs_r)
        DMPG_RS_IDLE: begin
          if (cmd_valid) begin
            rs_r <= DMPG_RS_BUSY;
            restore_strobe <= 1'b1;
            restore_req.keep_motor <= (restore_cmd_r == CMD_RESTORE_PART);
            restore_req.wipe_params <= (restore_cmd_r != CMD_CLEAR_RECORDS);
            restore_req.clear_records <= (restore_cmd_r == CMD_CLEAR_RECORDS);
          end
        end
        DMPG_RS_BUSY: begin
          if (restore_done) rs_r <= DMPG_RS_DONE;
        end
        DMPG_RS_DONE: begin
          rs_r <= DMPG_RS_IDLE;
          restore_req <= '0;
        end
        default: begin
          rs_r <= DMPG_RS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      param_write_allowed <= 1'b1;
      param_view_allowed <= 1'b1;
    end else begin
      param_write_allowed <= mod_ok;
      param_view_allowed <= view_ok;
    end
  end

  // read mux; guarded parameters read zero while protected and not unlocked
  logic [31:0] rdata;
  logic unmapped;
  always_comb begin
    rdata = 32'h0;
    unmapped = 1'b0;
    case (paddr)
      OFF_RESOLVER_ANGLE: rdata = 32'(angle_r);
      OFF_QUAD_POS: rdata = 32'(quad_pos_r);
      OFF_INDEX_REV: rdata = 32'(index_rev_r);
      OFF_RUN_STATE: rdata = 32'(run_word_r);
      OFF_SET_FREQ_PCT: rdata = 32'(set_pct_r);
      OFF_RUN_FREQ_PCT: rdata = 32'(run_pct_r);
      OFF_DI_FUNC_SEG1: rdata = 32'(seg1_r[31:0]);
      OFF_DI_FUNC_SEG2: rdata = {seg2_r, seg1_r[39:32]};
      OFF_USER_PASSWORD: rdata = view_ok ? 32'(password_r) : 32'h0;
      OFF_PASSWORD_ENTRY: rdata = 32'h0;
      OFF_WRITE_LOCK: rdata = view_ok ? 32'(lock_r) : 32'h0;
      OFF_QUICK_SELECT: rdata = view_ok ? 32'(quick_sel_r) : 32'h0;
      OFF_RESTORE_CMD: rdata = view_ok ? 32'(restore_cmd_r) : 32'h0;
      OFF_ACCESS_STATUS: rdata = {28'h0, unlocked_r, protect, mod_ok, view_ok};
      OFF_QUICK_KEY: rdata = 32'h0;
      OFF_DISPLAY_MODE: rdata = {24'h0, 6'h00, mode_r};
      default: unmapped = 1'b1;
    endcase
  end

  // error on unmapped access or on a refused parameter access, except a lock write refused while protected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable &&
                 (unmapped || (is_param_addr && (pwrite ? !mod_ok && paddr != OFF_WRITE_LOCK
                                                         : !view_ok)));
      if (psel && !penable && !pwrite) prdata <= rdata;
    end
  end

  logic unused_rd;
  assign unused_rd = rd_en;
endmodule
`default_nettype wire

// file: hw/dmpg_pkg.sv
/*
 drive monitor and parameter guard: shared constants, register map, types.
 assumes an apb register bus with 32-bit data and one aligned word per register.
*/
package dmpg_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_RESOLVER_ANGLE = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_QUAD_POS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_INDEX_REV = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_RUN_STATE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_SET_FREQ_PCT = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_RUN_FREQ_PCT = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_DI_FUNC_SEG1 = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_DI_FUNC_SEG2 = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_USER_PASSWORD = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_PASSWORD_ENTRY = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_WRITE_LOCK = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_QUICK_SELECT = 8'h2C;
  localparam logic [ADDR_W-1:0] OFF_RESTORE_CMD = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_ACCESS_STATUS = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_QUICK_KEY = 8'h38;
  localparam logic [ADDR_W-1:0] OFF_DISPLAY_MODE = 8'h3C;

  localparam logic [15:0] PASSWORD_RST = 16'h0000;
  localparam logic WRITE_LOCK_RST = 1'b0;
  localparam logic [7:0] QUICK_SELECT_RST = 8'h00;
  localparam logic [7:0] RESTORE_RST = 8'h00;
  localparam logic [11:0] RESOLVER_MAX = 12'hFFF;

  localparam logic [7:0] CMD_NONE = 8'h00;
  localparam logic [7:0] CMD_RESTORE_PART = 8'h01;
  localparam logic [7:0] CMD_RESTORE_ALL = 8'h02;
  localparam logic [7:0] CMD_CLEAR_RECORDS = 8'h04;

  localparam logic [1:0] DIR_STOP = 2'h0;
  localparam logic [1:0] DIR_FWD = 2'h1;
  localparam logic [1:0] DIR_REV = 2'h2;
  localparam logic [1:0] TREND_CONST = 2'h0;
  localparam logic [1:0] TREND_ACCEL = 2'h1;
  localparam logic [1:0] TREND_DECEL = 2'h2;

  localparam int unsigned QUICK_USER_BIT = 0;
  localparam int unsigned QUICK_CHANGED_BIT = 4;
  localparam int unsigned PCT_FULL = 10000;
  localparam int unsigned DI_FUNCS_LO = 40;
  localparam int unsigned DI_FUNCS_HI = 19;
  localparam logic [7:0] SYM_NONE = 8'h00;
  localparam logic [7:0] SYM_USER = 8'h75;
  localparam logic [7:0] SYM_CHANGED = 8'h63;

  typedef enum logic [1:0] {
    DMPG_MODE_FULL = 2'b00,
    DMPG_MODE_USER = 2'b01,
    DMPG_MODE_CHANGED = 2'b10
  } dmpg_mode_e;

  typedef enum logic [1:0] {
    DMPG_RS_IDLE = 2'b00,
    DMPG_RS_BUSY = 2'b01,
    DMPG_RS_DONE = 2'b10
  } dmpg_rst_e;

  typedef struct packed {
    logic [1:0] dir;
    logic [1:0] trend;
    logic dc_low;
  } dmpg_drive_s;

  typedef struct packed {
    logic keep_motor;
    logic wipe_params;
    logic clear_records;
  } dmpg_restore_s;
endpackage

// file: bench/dmpg_properties.sv
/*
 checker for dmpg_top: read fields, quick prefix and the restore handshake.
 assumes it is bound to dmpg_top and that everything runs on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module dmpg_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dmpg_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire dmpg_pkg::dmpg_drive_s drive_in,
  input wire logic restore_done,
  input wire dmpg_pkg::dmpg_restore_s restore_req,
  input wire logic restore_strobe,
  input wire logic param_write_allowed,
  input wire logic param_view_allowed,
  input wire logic [7:0] code_prefix
);
  import dmpg_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  function automatic logic rd(input logic [ADDR_W-1:0] a);
    return psel && !penable && !pwrite && paddr == a;
  endfunction
  prefix_legal_a: assert property (
    code_prefix == SYM_NONE || code_prefix == SYM_USER || code_prefix == SYM_CHANGED)
    else $error("code prefix outside the three symbols");
  view_for_write_a: assert property (
    param_write_allowed |-> param_view_allowed) else $error("write allowed without view");
  strobe_single_a: assert property (
    restore_strobe |=> !restore_strobe) else $error("restore strobe longer than a cycle");
  cmd_fields_a: assert property (
    restore_strobe |-> ##[0:1] (restore_req == 3'b110 || restore_req == 3'b010 ||
    restore_req == 3'b001)) else $error("restore request fields wrong");
  req_clears_a: assert property (
    restore_done && restore_req != 3'b000 |-> ##[1:4] restore_req == 3'b000)
    else $error("restore request not cleared after done");
  angle_width_a: assert property (
    rd(OFF_RESOLVER_ANGLE) |=> prdata[31:12] == 20'h00000) else $error("angle too wide");
  run_word_a: assert property (
    rd(OFF_RUN_STATE) && $stable(drive_in) |=> prdata == {27'h0, $past(drive_in.dc_low),
    $past(drive_in.trend), $past(drive_in.dir)}) else $error("run word fields wrong");
  di_hi_width_a: assert property (
    rd(OFF_DI_FUNC_SEG2) |=> prdata[31:27] == 5'h00) else $error("function bits past 59");
endmodule
bind dmpg_top dmpg_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .drive_in(drive_in),
  .restore_done(restore_done), .restore_req(restore_req), .restore_strobe(restore_strobe),
  .param_write_allowed(param_write_allowed), .param_view_allowed(param_view_allowed),
  .code_prefix(code_prefix));
`default_nettype wire

// file: bench/dmpg_field_model.sv
/*
 far-side model: quadrature encoder with index pulse, and the parameter store.
 assumes the bench calls step and zpulse just after a rising pclk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module dmpg_field_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic restore_strobe,
  output logic restore_done,
  output logic enc_a,
  output logic enc_b,
  output logic enc_z
);
  logic [1:0] ph;
  int dly;
  initial begin
    ph = 2'h0;
    enc_a = 1'b0;
    enc_b = 1'b0;
    enc_z = 1'b0;
  end
  // store takes a few cycles, so the busy window is visible
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly <= 0;
      restore_done <= 1'b0;
    end else begin
      restore_done <= (dly == 1);
      if (restore_strobe) dly <= 4;
      else if (dly != 0) dly <= dly - 1;
    end
  end
  // gray sequence 00,10,11,01: a leads b when turning forward
  task step(input logic fwd);
    ph = fwd ? ph + 2'h1 : ph - 2'h1;
    @(posedge pclk);
    enc_a <= ph[1] ^ ph[0];
    enc_b <= ph[1];
    repeat (8) @(posedge pclk);
  endtask
  task zpulse;
    @(posedge pclk);
    enc_z <= 1'b1;
    repeat (8) @(posedge pclk);
    enc_z <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// file: bench/tb_drive_monitor_and_param_guard.sv
/*
 self-checking bench for dmpg_top over apb with an encoder and store model.
 assumes zero-wait apb answers and counters cleared by reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_drive_monitor_and_param_guard;
  import dmpg_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic e;} dmpg_row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, restore_done, restore_strobe;
  logic enc_a, enc_b, enc_z, param_write_allowed, param_view_allowed;
  logic [7:0] paddr, code_prefix;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb;
  logic [11:0] resolver_angle_in;
  logic [15:0] set_freq, run_freq, max_output_frequency;
  logic [39:0] di_func_lo;
  logic [18:0] di_func_hi;
  logic e;
  dmpg_drive_s drive_in;
  dmpg_restore_s restore_req;
  dmpg_row_s rows [0:10];
  logic [7:0] cmds [0:4] = '{8'h01, 8'h02, 8'h04, 8'h03, 8'h05};
  logic [2:0] reqx [0:4] = '{3'h6, 3'h2, 3'h1, 3'h0, 3'h0};
  logic [7:0] qsel [0:4] = '{8'h11, 8'h11, 8'h11, 8'h10, 8'h10};
  logic [1:0] qmode [0:4] = '{2'h1, 2'h2, 2'h0, 2'h2, 2'h0};
  int n_errors = 0, total_checks = 0, n_strobe = 0, n0, k;
  dmpg_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z),
    .resolver_angle_in(resolver_angle_in), .drive_in(drive_in), .set_freq(set_freq),
    .run_freq(run_freq), .max_output_frequency(max_output_frequency),
    .di_func_lo(di_func_lo), .di_func_hi(di_func_hi), .restore_done(restore_done),
    .restore_req(restore_req), .restore_strobe(restore_strobe),
    .param_write_allowed(param_write_allowed), .param_view_allowed(param_view_allowed),
    .code_prefix(code_prefix));
  dmpg_field_model u_enc (.pclk(pclk), .presetn(presetn), .restore_strobe(restore_strobe),
    .restore_done(restore_done), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) if (restore_strobe === 1'b1) n_strobe++;
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && i < 20) begin
      @(posedge pclk);
      i++;
    end
    if (i == 20) begin
      chk(32'h1, 32'h0);
      conclude;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    chk(32'h1, 32'h0);
    conclude;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = {11'h0, 32'h0, 4'hF};
    resolver_angle_in = 12'hFFF;
    drive_in = '{DIR_REV, TREND_DECEL, 1'b1};
    {set_freq, run_freq, max_output_frequency} = {16'h09C4, 16'h1388, 16'h1388};
    di_func_lo = 40'hA512345678;
    di_func_hi = 19'h54321;
    presetn = 1'b0;
    rows[0] = '{OFF_RESOLVER_ANGLE, 32'h00000FFF, 1'b0};
    rows[1] = '{OFF_RUN_STATE, 32'h0000001A, 1'b0};
    rows[2] = '{OFF_SET_FREQ_PCT, 32'h00001388, 1'b0};
    rows[3] = '{OFF_RUN_FREQ_PCT, 32'h00002710, 1'b0};
    rows[4] = '{OFF_DI_FUNC_SEG1, di_func_lo[31:0], 1'b0};
    rows[5] = '{OFF_DI_FUNC_SEG2, {5'h0, di_func_hi, di_func_lo[39:32]}, 1'b0};
    rows[6] = '{OFF_USER_PASSWORD, 32'h0, 1'b0};
    rows[7] = '{OFF_WRITE_LOCK, 32'h0, 1'b0};
    rows[8] = '{OFF_QUICK_SELECT, 32'h0, 1'b0};
    rows[9] = '{OFF_RESTORE_CMD, 32'h0, 1'b0};
    rows[10] = '{8'h40, 32'h0, 1'b1};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i <= 10; i++) begin
      apb(1'b0, rows[i].a, 32'h0);
      chk({31'h0, e}, {31'h0, rows[i].e});
      if (!rows[i].e) chk(r, rows[i].d);
    end
    $display("register table done");
    rd_chk(OFF_QUAD_POS, 32'h0);
    repeat (4) u_enc.step(1'b1);
    rd_chk(OFF_QUAD_POS, 32'h4);
    repeat (5) u_enc.step(1'b0);
    rd_chk(OFF_QUAD_POS, 32'hFFFF);
    u_enc.step(1'b1);
    rd_chk(OFF_QUAD_POS, 32'h0);
    u_enc.zpulse;
    rd_chk(OFF_INDEX_REV, 32'h1);
    u_enc.step(1'b0);
    u_enc.zpulse;
    u_enc.zpulse;
    rd_chk(OFF_INDEX_REV, 32'hFFFF);
    $display("encoder done");
    apb(1'b1, OFF_USER_PASSWORD, 32'h1234);
    rd_chk(OFF_ACCESS_STATUS, 32'hF);
    rd_chk(OFF_USER_PASSWORD, 32'h1234);
    apb(1'b1, OFF_PASSWORD_ENTRY, 32'h1111);
    rd_chk(OFF_USER_PASSWORD, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk({31'h0, param_view_allowed}, 32'h0);
    apb(1'b1, OFF_PASSWORD_ENTRY, 32'h1234);
    rd_chk(OFF_USER_PASSWORD, 32'h1234);
    apb(1'b1, OFF_USER_PASSWORD, 32'h0);
    apb(1'b0, OFF_ACCESS_STATUS, 32'h0);
    chk({29'h0, r[2:0]}, 32'h3);
    rd_chk(OFF_USER_PASSWORD, 32'h0);
    apb(1'b1, OFF_WRITE_LOCK, 32'h1);
    @(posedge pclk);
    chk({31'h0, param_write_allowed}, 32'h0);
    apb(1'b1, OFF_QUICK_SELECT, 32'h11);
    chk({31'h0, e}, 32'h1);
    rd_chk(OFF_QUICK_SELECT, 32'h0);
    apb(1'b1, OFF_WRITE_LOCK, 32'h0);
    @(posedge pclk);
    chk({31'h0, param_write_allowed}, 32'h1);
    $display("guard done");
    for (int j = 0; j < 5; j++) begin
      apb(1'b1, OFF_QUICK_SELECT, {24'h0, qsel[j]});
      apb(1'b1, OFF_QUICK_KEY, 32'h1);
      repeat (3) @(posedge pclk);
      chk({24'h0, code_prefix}, qmode[j] == 2'h1 ? 32'h75 : qmode[j] == 2'h2 ? 32'h63 : 32'h0);
      rd_chk(OFF_DISPLAY_MODE, {30'h0, qmode[j]});
    end
    $display("quick mode done");
    for (int j = 0; j < 5; j++) begin
      n0 = n_strobe;
      apb(1'b1, OFF_RESTORE_CMD, {24'h0, cmds[j]});
      k = 0;
      while (restore_req !== reqx[j] && k < 30) begin
        @(posedge pclk);
        k++;
      end
      chk({29'h0, restore_req}, {29'h0, reqx[j]});
      if (k == 30) conclude;
      k = 0;
      while (restore_req !== 3'h0 && k < 30) begin
        @(posedge pclk);
        k++;
      end
      if (k == 30) begin
        chk(32'h1, 32'h0);
        conclude;
      end
      repeat (4) @(posedge pclk);
      rd_chk(OFF_RESTORE_CMD, 32'h0);
      chk(32'(n_strobe - n0), (reqx[j] != 3'h0) ? 32'h1 : 32'h0);
    end
    $display("restore done");
    set_freq <= 16'hF63C;
    @(posedge pclk);
    rd_chk(OFF_SET_FREQ_PCT, 32'h0000EC78);
    apb(1'b1, OFF_WRITE_LOCK, 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({30'h0, param_write_allowed, param_view_allowed}, 32'h3);
    chk({23'h0, restore_strobe, code_prefix}, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(OFF_WRITE_LOCK, 32'h0);
    $display("reset done");
    conclude;
  end
endmodule
`default_nettype wire
